// [core/pwdc_pkg.sv]
// Purpose: shared constants and types of the preamble wake and demodulator block
// Assumes: 100 MHz core clock, 8-bit register port
// Notes: offsets are register indices on the 8-bit register port
package pwdc_pkg;
  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_DEMODULATOR_CONFIG = 8'h00;
  localparam logic [7:0] OFS_ATTACK = 8'h03;
  localparam logic [7:0] OFS_RELEASE = 8'h04;
  localparam logic [7:0] OFS_IF_FILT = 8'h02;
  localparam logic [7:0] OFS_PAT_LEN = 8'h0C;
  localparam logic [7:0] OFS_PAT_LO = 8'h0D;
  localparam logic [7:0] OFS_PAT_HI = 8'h0E;
  localparam logic [7:0] OFS_INT_STAT = 8'h13;
  localparam logic [7:0] OFS_POWER = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h15;
  localparam logic [7:0] OFS_DET_INT = 8'h17;
  localparam logic [7:0] OFS_WAIT_RATIO = 8'h18;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TCTRL_LSB = 0;
  localparam int FSKD_LSB = 3;
  localparam int CHF_LSB = 0;
  localparam int IF_SEL_BIT = 3;
  localparam int MOD_SEL_BIT = 4;
  localparam int XO_EN_BIT = 0;
  localparam int POLL_EN_BIT = 1;
  localparam int RX_EN_BIT = 2;
  localparam int DET_FLAG_BIT = 0;
  localparam int OVR_FLAG_BIT = 1;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_DEMODULATOR_CONFIG = 8'h00;
  localparam logic [7:0] RST_IF_FILT = 8'h00;
  localparam logic [7:0] RST_ATTACK = 8'hC0;
  localparam logic [7:0] RST_RELEASE = 8'h40;
  localparam logic [3:0] RST_PAT_LEN = 4'hF;
  localparam logic [15:0] RST_PAT = 16'h0000;
  localparam logic [7:0] RST_DET_INT = 8'h00;
  localparam logic [6:0] RST_WAIT_RATIO = 7'h00;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int DET_STEP_PS = 80000000;
  localparam int DET_STEP_CYCLES = DET_STEP_PS / CLK_PERIOD_PS;
  localparam logic [15:0] DET_BASE_STEPS = 16'h0006;
  localparam int OVERSAMPLE = 16;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_STANDBY,
    ST_CONT_RX,
    ST_POLL_RX,
    ST_WAIT
  } pwdc_state_t;

  typedef struct packed {
    logic if_sel;
    logic [2:0] channel_filter_select;
    logic modulation_select;
    logic [2:0] demodulator_config_time_control;
    logic [2:0] fsk_demodulator_config_setting;
  } pwdc_demodulator_config_cfg_t;
endpackage : pwdc_pkg

// [core/pwdc_matcher.sv]
// Purpose: manchester preamble matcher on demodulated half-bits
// Assumes: half-bit strobe from the demodulator on the core clock
// Notes: match is a one-cycle registered pulse
`timescale 1ns/10ps
module pwdc_matcher (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic restart_i,
  input wire logic half_stb_i,
  input wire logic half_bit_i,
  input wire logic [15:0] word_i,
  input wire logic [3:0] len_i,
  output logic match_o
);
  typedef struct packed {
    logic [31:0] hist;
    logic [5:0] fill;
    logic hit;
  } pwdc_match_t;

  pwdc_match_t s_reg;
  pwdc_match_t s_next;
  logic [31:0] mask;
  logic [5:0] need;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] pwdc_encode(input logic [15:0] w, input logic inv);
    logic [31:0] e;
    e = 32'h00000000;
    for (int i = 0; i < 16; i++)
    begin
      e[2*i] = w[i] ^ inv;
      e[2*i+1] = ~w[i] ^ inv;
    end
    return e;
  endfunction : pwdc_encode

  function automatic logic pwdc_hit(input logic [31:0] h, input logic [31:0] e,
                                    input logic [31:0] m);
    return ((h ^ e) & m) == 32'h00000000;
  endfunction : pwdc_hit

  always_comb
  begin
    need = {1'b0, len_i, 1'b0} + 6'h02;
    mask = 32'h00000000;
    for (int i = 0; i < 32; i++)
    begin
      mask[i] = (6'(i) < need);
    end
    s_next = s_reg;
    s_next.hit = 1'b0;
    if (restart_i)
    begin
      s_next.fill = 6'h00;
      s_next.hist = 32'h00000000;
    end
    else if (half_stb_i)
    begin
      s_next.hist = {s_reg.hist[30:0], half_bit_i};
      if (s_reg.fill != 6'h20)
      begin
        s_next.fill = s_reg.fill + 6'h01;
      end
      // either phase of the encoded word counts
      s_next.hit = (s_next.fill >= need)
        && (pwdc_hit(s_next.hist, pwdc_encode(word_i, 1'b0), mask)
        || pwdc_hit(s_next.hist, pwdc_encode(word_i, 1'b1), mask));
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_reg <= '0;
    end
    else if (ce_i)
    begin
      s_reg <= s_next;
    end
  end

  assign match_o = s_reg.hit;
endmodule : pwdc_matcher

// [core/pwdc_top.sv]
// Purpose: preamble wake, data pin and demodulator configuration of the receiver baseband
// Assumes: register port driven by the serial interface logic on the core clock
// Notes: demodulated data, strobes and strength come from core-clock logic
//
// Operation
// - only pattern bits up to the programmed length take part in matching.
// - a match is declared at either phase of the encoded pattern.
// - continuous receive drives the data pin with demodulated data.
// - half-bits closer than sixteen samples flag an over-rate error.
// - polling receive holds data high; no match returns to wait high.
// - after a match the data pin goes low on entering wait.
// - reading interrupt status raises data, clears polling and enters standby.
// - unread status repeats polling high and wait low cycles.
// - IF select bit picks 400 kHz at 0, 200 kHz at 1.
// - three-bit channel filter select sets receiver bandwidth.
// - modulation select picks amplitude-shift at 0, frequency-shift at 1.
// - demodulator register holds time control and FSK setting fields.
// - FSK demodulator setting is applied only in frequency-shift mode.
// - gain steps down above attack and up below release threshold.
// - status read clears the detected flag and the polling enable.
// - sixteen-bit pattern in two registers, bit 0 most recent.
// - length field value plus one gives the pattern length.
// - detection interval is 0.48 ms plus 0.08 ms per step.
`timescale 1ns/10ps
module pwdc_top #(
  parameter int STEP_CYCLES = pwdc_pkg::DET_STEP_CYCLES
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  output logic [7:0] REG_RDATA_O,
  input wire logic SAMPLE_STB_I,
  input wire logic HALF_STB_I,
  input wire logic DEMODULATOR_CONFIG_BIT_I,
  input wire logic RSSI_STB_I,
  input wire logic [7:0] RSSI_RAW_I,
  output logic DATA_O,
  output logic RX_ON_O,
  output logic GAIN_LOW_O,
  output pwdc_pkg::pwdc_demodulator_config_cfg_t DEMODULATOR_CONFIG_CFG_O
);
  typedef struct packed {
    pwdc_pkg::pwdc_state_t st;
    logic [7:0] demodulator_config;
    logic [7:0] if_filt;
    logic [7:0] attack;
    logic [7:0] release_th;
    logic [3:0] pat_len;
    logic [15:0] pat;
    logic [7:0] det_int;
    logic [6:0] ratio;
    logic xo_en;
    logic poll_en;
    logic rx_en;
    logic det_flag;
    logic ovr_flag;
    logic [15:0] cyc;
    logic [15:0] steps;
    logic [4:0] ovs;
    logic [7:0] rdata;
    logic data;
    logic gain_low;
  } pwdc_regs_t;

  pwdc_regs_t s_reg;
  pwdc_regs_t s_next;
  logic match;
  logic active;
  logic step_end;
  logic [15:0] det_steps;
  logic [15:0] wait_steps;
  logic stat_rd;
  logic [7:0] rd_val;

  // ---------------------------------------------------------------
  // preamble matcher
  // ---------------------------------------------------------------
  pwdc_matcher u_matcher (
    .clk_i(CORE_CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .restart_i(s_reg.st != pwdc_pkg::ST_POLL_RX),
    .half_stb_i(HALF_STB_I),
    .half_bit_i(DEMODULATOR_CONFIG_BIT_I),
    .word_i(s_reg.pat),
    .len_i(s_reg.pat_len),
    .match_o(match)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    active = (s_reg.st == pwdc_pkg::ST_CONT_RX) || (s_reg.st == pwdc_pkg::ST_POLL_RX);
    step_end = (s_reg.cyc == 16'(STEP_CYCLES - 1));
    det_steps = pwdc_pkg::DET_BASE_STEPS + {8'h00, s_reg.det_int};
    wait_steps = 16'(det_steps * ({9'h000, s_reg.ratio} + 16'h0001));
    stat_rd = REG_RD_I && (REG_ADDR_I == pwdc_pkg::OFS_INT_STAT);
    // register read mux
    case (REG_ADDR_I)
      pwdc_pkg::OFS_DEMODULATOR_CONFIG: rd_val = s_reg.demodulator_config;
      pwdc_pkg::OFS_IF_FILT: rd_val = s_reg.if_filt;
      pwdc_pkg::OFS_ATTACK: rd_val = s_reg.attack;
      pwdc_pkg::OFS_RELEASE: rd_val = s_reg.release_th;
      pwdc_pkg::OFS_PAT_LEN: rd_val = {4'h0, s_reg.pat_len};
      pwdc_pkg::OFS_PAT_LO: rd_val = s_reg.pat[7:0];
      pwdc_pkg::OFS_PAT_HI: rd_val = s_reg.pat[15:8];
      pwdc_pkg::OFS_INT_STAT: rd_val = {6'h00, s_reg.ovr_flag, s_reg.det_flag};
      pwdc_pkg::OFS_POWER: rd_val = {5'h00, s_reg.rx_en, s_reg.poll_en, s_reg.xo_en};
      pwdc_pkg::OFS_STATE: rd_val = {5'h00, s_reg.st};
      pwdc_pkg::OFS_DET_INT: rd_val = s_reg.det_int;
      pwdc_pkg::OFS_WAIT_RATIO: rd_val = {1'b0, s_reg.ratio};
      default: rd_val = 8'h00;
    endcase
    if (REG_RD_I)
    begin
      s_next.rdata = rd_val;
    end
    // register writes; configuration is locked while the receiver runs
    if (REG_WR_I)
    begin
      if (REG_ADDR_I == pwdc_pkg::OFS_POWER)
      begin
        s_next.xo_en = REG_WDATA_I[pwdc_pkg::XO_EN_BIT];
        s_next.poll_en = REG_WDATA_I[pwdc_pkg::POLL_EN_BIT];
        s_next.rx_en = REG_WDATA_I[pwdc_pkg::RX_EN_BIT];
      end
      else if (!active)
      begin
        case (REG_ADDR_I)
          pwdc_pkg::OFS_DEMODULATOR_CONFIG: s_next.demodulator_config = REG_WDATA_I;
          pwdc_pkg::OFS_IF_FILT: s_next.if_filt = REG_WDATA_I;
          pwdc_pkg::OFS_ATTACK: s_next.attack = REG_WDATA_I;
          pwdc_pkg::OFS_RELEASE: s_next.release_th = REG_WDATA_I;
          pwdc_pkg::OFS_PAT_LEN: s_next.pat_len = REG_WDATA_I[3:0];
          pwdc_pkg::OFS_PAT_LO: s_next.pat[7:0] = REG_WDATA_I;
          pwdc_pkg::OFS_PAT_HI: s_next.pat[15:8] = REG_WDATA_I;
          pwdc_pkg::OFS_DET_INT: s_next.det_int = REG_WDATA_I;
          pwdc_pkg::OFS_WAIT_RATIO: s_next.ratio = REG_WDATA_I[6:0];
          default: s_next.demodulator_config = s_reg.demodulator_config;
        endcase
      end
    end
    // status read clears; a new event in the same cycle wins
    if (stat_rd)
    begin
      s_next.det_flag = 1'b0;
      s_next.ovr_flag = 1'b0;
      s_next.poll_en = 1'b0;
    end
    if (match)
    begin
      s_next.det_flag = 1'b1;
    end
    // oversampling check on half-bit spacing
    if (HALF_STB_I)
    begin
      if (active && s_reg.ovs < 5'(pwdc_pkg::OVERSAMPLE - 1))
      begin
        s_next.ovr_flag = 1'b1;
      end
      s_next.ovs = 5'h00;
    end
    else if (SAMPLE_STB_I && s_reg.ovs != 5'h1F)
    begin
      s_next.ovs = s_reg.ovs + 5'h01;
    end
    // interval timing
    s_next.cyc = step_end ? 16'h0000 : s_reg.cyc + 16'h0001;
    if (step_end)
    begin
      s_next.steps = s_reg.steps + 16'h0001;
    end
    // power state machine
    case (s_reg.st)
      pwdc_pkg::ST_SLEEP:
      begin
        if (s_next.xo_en)
        begin
          s_next.st = pwdc_pkg::ST_STANDBY;
        end
      end
      pwdc_pkg::ST_STANDBY:
      begin
        s_next.cyc = 16'h0000;
        s_next.steps = 16'h0000;
        if (!s_next.xo_en)
        begin
          s_next.st = pwdc_pkg::ST_SLEEP;
        end
        else if (s_next.poll_en)
        begin
          s_next.st = pwdc_pkg::ST_WAIT;
        end
        else if (s_next.rx_en)
        begin
          s_next.st = pwdc_pkg::ST_CONT_RX;
        end
      end
      pwdc_pkg::ST_CONT_RX:
      begin
        if (!s_next.rx_en || !s_next.xo_en)
        begin
          s_next.st = pwdc_pkg::ST_STANDBY;
        end
      end
      pwdc_pkg::ST_POLL_RX:
      begin
        if (!s_next.poll_en || !s_next.xo_en)
        begin
          s_next.st = pwdc_pkg::ST_STANDBY;
        end
        else if (step_end && s_reg.steps == det_steps - 16'h0001)
        begin
          s_next.st = pwdc_pkg::ST_WAIT;
          s_next.steps = 16'h0000;
        end
      end
      pwdc_pkg::ST_WAIT:
      begin
        if (!s_next.poll_en || !s_next.xo_en)
        begin
          s_next.st = pwdc_pkg::ST_STANDBY;
        end
        else if (step_end && s_reg.steps == wait_steps - 16'h0001)
        begin
          s_next.st = pwdc_pkg::ST_POLL_RX;
          s_next.steps = 16'h0000;
        end
      end
      default: s_next.st = pwdc_pkg::ST_SLEEP;
    endcase
    // data pin
    if (s_next.st == pwdc_pkg::ST_CONT_RX)
    begin
      s_next.data = DEMODULATOR_CONFIG_BIT_I;
    end
    else if (s_next.st == pwdc_pkg::ST_WAIT && s_next.det_flag
      && (s_reg.st == pwdc_pkg::ST_POLL_RX || !s_reg.data))
    begin
      // falls only on wait entry; a late match waits for the next entry
      s_next.data = 1'b0;
    end
    else
    begin
      s_next.data = 1'b1;
    end
    // two-threshold gain control
    if (RSSI_STB_I && active)
    begin
      if (RSSI_RAW_I > s_reg.attack)
      begin
        s_next.gain_low = 1'b1;
      end
      else if (RSSI_RAW_I < s_reg.release_th)
      begin
        s_next.gain_low = 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I)
  begin
    if (RESET_I)
    begin
      s_reg <= '0;
      s_reg.st <= pwdc_pkg::ST_SLEEP;
      s_reg.demodulator_config <= pwdc_pkg::RST_DEMODULATOR_CONFIG;
      s_reg.if_filt <= pwdc_pkg::RST_IF_FILT;
      s_reg.attack <= pwdc_pkg::RST_ATTACK;
      s_reg.release_th <= pwdc_pkg::RST_RELEASE;
      s_reg.pat_len <= pwdc_pkg::RST_PAT_LEN;
      s_reg.pat <= pwdc_pkg::RST_PAT;
      s_reg.det_int <= pwdc_pkg::RST_DET_INT;
      s_reg.ratio <= pwdc_pkg::RST_WAIT_RATIO;
      s_reg.data <= 1'b1;
    end
    else if (CE_I)
    begin
      s_reg <= s_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign REG_RDATA_O = s_reg.rdata;
  assign DATA_O = s_reg.data;
  assign GAIN_LOW_O = s_reg.gain_low;
  assign RX_ON_O = (s_reg.st == pwdc_pkg::ST_CONT_RX) || (s_reg.st == pwdc_pkg::ST_POLL_RX);
  // whole struct in one assignment, fields in declaration order
  assign DEMODULATOR_CONFIG_CFG_O = {
    s_reg.if_filt[pwdc_pkg::IF_SEL_BIT],
    s_reg.if_filt[pwdc_pkg::CHF_LSB +: 3],
    s_reg.if_filt[pwdc_pkg::MOD_SEL_BIT],
    s_reg.demodulator_config[pwdc_pkg::TCTRL_LSB +: 3],
    (s_reg.if_filt[pwdc_pkg::MOD_SEL_BIT]
      ? s_reg.demodulator_config[pwdc_pkg::FSKD_LSB +: 3] : 3'h0)
  };
endmodule : pwdc_top

// [verif/pwdc_top_assertions.sv]
// Purpose: port checks of the preamble wake block
// Assumes: single core clock domain, synchronous reset
// Notes: bound to pwdc_top after the module
`timescale 1ns/10ps
module pwdc_top_chk #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic DEMODULATOR_CONFIG_BIT_I,
  input wire logic RSSI_STB_I,
  input wire logic [7:0] RSSI_RAW_I,
  input wire logic DATA_O,
  input wire logic RX_ON_O,
  input wire logic GAIN_LOW_O,
  input wire pwdc_pkg::pwdc_demodulator_config_cfg_t DEMODULATOR_CONFIG_CFG_O
);
  default clocking @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RESET_I);
  wire logic wr_ok = REG_WR_I && CE_I && !RX_ON_O;
  wire logic rs_ok = RSSI_STB_I && CE_I && RX_ON_O;

  AST_STREAM: assert property (RX_ON_O && $past(RX_ON_O) && $past(CE_I) && !DATA_O
    |-> !$past(DEMODULATOR_CONFIG_BIT_I)) else $error("data pin differs from demodulated bit");
  AST_WAKE_LOW: assert property ($fell(DATA_O) && !RX_ON_O |-> $past(RX_ON_O))
    else $error("data pin fell outside poll exit");
  AST_READ_RAISE: assert property (REG_RD_I && CE_I && REG_ADDR_I == 8'h13
    && !DATA_O && !RX_ON_O |=> DATA_O ##1 (DATA_O && !RX_ON_O))
    else $error("status read did not raise data pin");
  AST_FSK_ONLY: assert property (!DEMODULATOR_CONFIG_CFG_O.modulation_select
    |-> DEMODULATOR_CONFIG_CFG_O.fsk_demodulator_config_setting == 3'h0) else $error("fsk setting live in ask mode");
  AST_ATTACK: assert property (rs_ok && RSSI_RAW_I == 8'hFF |=> GAIN_LOW_O)
    else $error("gain not reduced on strong signal");
  AST_RELEASE: assert property (rs_ok && RSSI_RAW_I == 8'h00 |=> !GAIN_LOW_O)
    else $error("gain not restored on weak signal");
  AST_IF_CFG: assert property (wr_ok && REG_ADDR_I == 8'h02 |=>
    {DEMODULATOR_CONFIG_CFG_O.if_sel, DEMODULATOR_CONFIG_CFG_O.channel_filter_select, DEMODULATOR_CONFIG_CFG_O.modulation_select}
    == {$past(REG_WDATA_I[3]), $past(REG_WDATA_I[2:0]), $past(REG_WDATA_I[4])})
    else $error("if filter select not applied");
  AST_TCTRL: assert property (wr_ok && REG_ADDR_I == 8'h00 |=>
    DEMODULATOR_CONFIG_CFG_O.demodulator_config_time_control == $past(REG_WDATA_I[2:0]))
    else $error("time control not applied");
  cover property ($fell(DATA_O) && !RX_ON_O);
  cover property (RX_ON_O && $past(RX_ON_O) && !DATA_O);
  cover property ($rose(GAIN_LOW_O));
endmodule : pwdc_top_chk

bind pwdc_top pwdc_top_chk #(
  .STEP_CYCLES(STEP_CYCLES)
) i_pwdc_top_chk (
  .CORE_CLK_I(CORE_CLK_I),
  .RESET_I(RESET_I),
  .CE_I(CE_I),
  .REG_ADDR_I(REG_ADDR_I),
  .REG_WR_I(REG_WR_I),
  .REG_RD_I(REG_RD_I),
  .REG_WDATA_I(REG_WDATA_I),
  .DEMODULATOR_CONFIG_BIT_I(DEMODULATOR_CONFIG_BIT_I),
  .RSSI_STB_I(RSSI_STB_I),
  .RSSI_RAW_I(RSSI_RAW_I),
  .DATA_O(DATA_O),
  .RX_ON_O(RX_ON_O),
  .GAIN_LOW_O(GAIN_LOW_O),
  .DEMODULATOR_CONFIG_CFG_O(DEMODULATOR_CONFIG_CFG_O)
);

// [verif/pwdc_host.sv]
// Purpose: host controller model on register port and data pin
// Assumes: register strobes one cycle, read data one cycle later
// Notes: expected read values queued for the bench monitor
`timescale 1ns/10ps
module pwdc_host (
  input wire logic clk_i,
  input wire logic data_i,
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] wdata_o
);
  logic [15:0] exp_q[$];
  logic auto_wake = 1'b0;
  int dly = 0;
  initial
  begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    exp_q.push_back({a, e});
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
  endtask : rd
  // wake response, prompt or slow
  always @(negedge data_i)
  begin
    if (auto_wake)
    begin
      auto_wake = 1'b0;
      repeat (dly) @(posedge clk_i);
      rd(8'h13, 8'h01);
      rd(8'h14, 8'h01);
      rd(8'h15, 8'h01);
      wr(8'h14, 8'h05);
    end
  end
endmodule : pwdc_host

// [verif/testbench.sv]
// Purpose: self-checking bench of pwdc_top
// Assumes: short detection step for simulation
// Notes: reads compared by a monitor against queued notes
`timescale 1ns/10ps
`define CHK(nm, e, g) \
  begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
  logic CORE_CLK_I, RESET_I = 1'b1, CE_I = 1'b1, SAMPLE_STB_I = 1'b1;
  logic HALF_STB_I = 1'b0, DEMODULATOR_CONFIG_BIT_I = 1'b0, RSSI_STB_I = 1'b0, rd_d = 1'b0;
  logic [7:0] RSSI_RAW_I = 8'h00, REG_ADDR_I, REG_WDATA_I, REG_RDATA_O;
  logic REG_WR_I, REG_RD_I, DATA_O, RX_ON_O, GAIN_LOW_O;
  pwdc_pkg::pwdc_demodulator_config_cfg_t DEMODULATOR_CONFIG_CFG_O, saved;
  int n_mismatch = 0, num_checks = 0, n;
  logic [15:0] note;
  logic [7:0] ra[8] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h0C, 8'h13, 8'h14, 8'h7F};
  logic [7:0] rv[8] = '{8'h00, 8'h00, 8'hC0, 8'h40, 8'h0F, 8'h00, 8'h00, 8'h00};
  logic [7:0] gv[6] = '{8'hC1, 8'hC0, 8'h3F, 8'h40, 8'hFF, 8'h00};
  pwdc_top #(.STEP_CYCLES(4)) i_dut (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I),
    .CE_I(CE_I), .REG_ADDR_I(REG_ADDR_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_RDATA_O(REG_RDATA_O), .SAMPLE_STB_I(SAMPLE_STB_I),
    .HALF_STB_I(HALF_STB_I), .DEMODULATOR_CONFIG_BIT_I(DEMODULATOR_CONFIG_BIT_I), .RSSI_STB_I(RSSI_STB_I),
    .RSSI_RAW_I(RSSI_RAW_I), .DATA_O(DATA_O), .RX_ON_O(RX_ON_O),
    .GAIN_LOW_O(GAIN_LOW_O), .DEMODULATOR_CONFIG_CFG_O(DEMODULATOR_CONFIG_CFG_O));
  pwdc_host i_host (.clk_i(CORE_CLK_I), .data_i(DATA_O), .addr_o(REG_ADDR_I),
    .wr_o(REG_WR_I), .rd_o(REG_RD_I), .wdata_o(REG_WDATA_I));
  initial
  begin
    CORE_CLK_I = 1'b0;
    forever #5 CORE_CLK_I = ~CORE_CLK_I;
  end
  always @(posedge CORE_CLK_I)
  begin
    if (rd_d)
    begin
      note = i_host.exp_q.pop_front();
      `CHK($sformatf("reg %h", note[15:8]), note[7:0], REG_RDATA_O)
    end
    rd_d <= REG_RD_I && CE_I;
  end
  task automatic wait_for(input logic on_rx, input logic v);
    n = 0;
    do
    begin
      @(posedge CORE_CLK_I);
      #1;
      n++;
    end while (((on_rx ? RX_ON_O : DATA_O) !== v) && n < 1000);
    if (n >= 1000) `CHK("wait", 1'b1, 1'b0)
  endtask : wait_for
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    #400000;
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    int sg;
    logic b, g;
    logic [2:0] chf, fsk, tc;
    logic [7:0] c0, c2, r;
    void'($urandom(27614));
    repeat (16) @(posedge CORE_CLK_I);
    RESET_I <= 1'b0;
    i_host.wr(8'h7F, 8'hFF);
    foreach (ra[i]) i_host.rd(ra[i], rv[i]);
    $display("test reset_values done");
    for (int m = 0; m < 2; m++)
      for (int f = 0; f < 2; f++)
      begin
        chf = 3'($urandom % 5);
        fsk = 3'($urandom % 7);
        sg = $urandom % 8;
        tc = m ? 3'(4 - chf) : 3'((sg + 2 > 7) ? 7 : sg + 2);
        c2 = {3'h0, 1'(m), 1'(f), chf};
        c0 = {2'h0, fsk, tc};
        i_host.wr(8'h02, c2);
        i_host.wr(8'h00, c0);
        @(posedge CORE_CLK_I);
        #1;
        `CHK("cfg", {1'(f), chf, 1'(m), tc, m ? fsk : 3'h0}, DEMODULATOR_CONFIG_CFG_O)
        i_host.rd(8'h02, c2);
        i_host.rd(8'h00, c0);
      end
    $display("test config done");
    i_host.wr(8'h14, 8'h01);
    i_host.wr(8'h0C, 8'h01);
    i_host.wr(8'h0D, 8'hFE);
    i_host.wr(8'h0E, 8'hFF);
    i_host.wr(8'h17, 8'h14);
    i_host.wr(8'h18, 8'h00);
    i_host.wr(8'h14, 8'h03);
    wait_for(1, 1);
    wait_for(1, 0);
    `CHK("poll length", 104, n)
    `CHK("no match data", 1'b1, DATA_O)
    wait_for(1, 1);
    for (int i = 0; i < 4; i++)
    begin
      repeat (15) @(posedge CORE_CLK_I);
      HALF_STB_I <= 1'b1;
      DEMODULATOR_CONFIG_BIT_I <= (i == 0 || i == 3);
      @(posedge CORE_CLK_I);
      HALF_STB_I <= 1'b0;
    end
    wait_for(1, 0);
    `CHK("wake data", 1'b0, DATA_O)
    wait_for(1, 1);
    `CHK("repoll data", 1'b1, DATA_O)
    i_host.dly = $urandom % 8;
    i_host.auto_wake = 1'b1;
    wait_for(1, 0);
    `CHK("rewake data", 1'b0, DATA_O)
    wait_for(0, 1);
    wait_for(1, 1);
    $display("test wake done");
    for (int i = 0; i < 24; i++)
    begin
      b = 1'($urandom);
      @(posedge CORE_CLK_I);
      DEMODULATOR_CONFIG_BIT_I <= b;
      @(posedge CORE_CLK_I);
      #1;
      `CHK("stream", b, DATA_O)
    end
    g = 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      r = (i < 6) ? gv[i] : 8'($urandom);
      @(posedge CORE_CLK_I);
      RSSI_STB_I <= 1'b1;
      RSSI_RAW_I <= r;
      @(posedge CORE_CLK_I);
      RSSI_STB_I <= 1'b0;
      #1;
      g = (r > 8'hC0) ? 1'b1 : (r < 8'h40) ? 1'b0 : g;
      `CHK("gain", g, GAIN_LOW_O)
    end
    @(posedge CORE_CLK_I);
    CE_I <= 1'b0;
    DEMODULATOR_CONFIG_BIT_I <= ~DATA_O;
    repeat (3) @(posedge CORE_CLK_I);
    #1;
    `CHK("frozen data", ~DEMODULATOR_CONFIG_BIT_I, DATA_O)
    CE_I <= 1'b1;
    repeat (2)
    begin
      @(posedge CORE_CLK_I);
      HALF_STB_I <= 1'b1;
      @(posedge CORE_CLK_I);
      HALF_STB_I <= 1'b0;
    end
    saved = DEMODULATOR_CONFIG_CFG_O;
    i_host.wr(8'h02, 8'h1F);
    #1;
    `CHK("refused write", saved, DEMODULATOR_CONFIG_CFG_O)
    i_host.wr(8'h14, 8'h01);
    i_host.rd(8'h13, 8'h02);
    i_host.rd(8'h15, 8'h01);
    repeat (4) @(posedge CORE_CLK_I);
    $display("test stream_gain done");
    finish_test();
  end
endmodule : testbench
